// file: design/caccs_bounds.v
// Bounds test: every byte of an access lies inside [base, top).
// Assumes top is one past the last permitted byte, held one bit wider than an address.
`timescale 1ns/1ps
`default_nettype none
module caccs_bounds (
  input  wire [63:0] addr_i,
  input  wire [4:0]  bytes_i,
  input  wire [63:0] base_i,
  input  wire [64:0] top_i,
  output wire        in_bounds_o
);
  wire [64:0] last_end;

  // The end is computed at 65 bits so an access wrapping the address space fails.
  assign last_end    = {1'b0, addr_i} + {60'h0, bytes_i};
  assign in_bounds_o = (addr_i >= base_i) && (last_end <= top_i);
endmodule
`default_nettype wire

// file: design/caccs_checker.v
// Capability access checker for reserved loads, conditional stores and FP loads and stores.
// Assumes the pipeline presents one decoded-from-word request per valid pulse on the core clock.
//
// Summary of operation
// (R01) Capability mode authorises the access with the base capability operand.
// (R02) Legacy mode authorises with the default data capability; integer base gives address.
// (R03) Authority tag clear raises a data fault with tag cause.
// (R04) Sealed authority raises a data fault with seal cause.
// (R05) Loads need read permission, else permission data fault.
// (R06) Stores need write permission, else permission data fault.
// (R07) Any accessed byte outside authority bounds raises a length data fault.
// (R08) Failures report data-fault type and the matching cause code.
// (R09) Misaligned reserved loads, capability form too, raise load address misaligned.
// (R10) Misaligned conditional stores raise misaligned with Zam, else store access fault.
// (R11) Doubleword conditional store only on RV64; byte and halfword need Zabhlrsc.
// (R12) Capability forms need purecap plus A; legacy forms need legacy plus A; byte and halfword reserved forms need no A.
// (R13) FP double needs D, word F, half Zfh or Zfhmin, plus mode extension.
// (R14) Whole-capability reserved forms decode differently on 64-bit and 32-bit bases.
// (R15) Capability conditional store uses result register, capability source, zero-offset base.
// (R16) Simultaneous failures report one cause: tag, seal, permission, then bounds.
`timescale 1ns/1ps
`default_nettype none
`include "caccs_regs.vh"
module caccs_checker (
  input  wire        clk_sys_i,
  input  wire        reset_n_i,
  input  wire        req_valid_i,
  input  wire [31:0] instr_i,
  input  wire        cap_mode_i,
  input  wire        cfg_rv64_i,
  input  wire        cfg_ext_a_i,
  input  wire        cfg_purecap_i,
  input  wire        cfg_legacy_i,
  input  wire        cfg_zabhlrsc_i,
  input  wire        cfg_zam_i,
  input  wire        cfg_ext_f_i,
  input  wire        cfg_ext_d_i,
  input  wire        cfg_zfh_i,
  input  wire [63:0] int_base_addr_i,
  input  wire        base_cap_tag_i,
  input  wire        base_cap_sealed_i,
  input  wire        base_cap_perm_r_i,
  input  wire        base_cap_perm_w_i,
  input  wire [63:0] base_cap_addr_i,
  input  wire [63:0] base_cap_base_i,
  input  wire [64:0] base_cap_top_i,
  input  wire        ddc_tag_i,
  input  wire        ddc_sealed_i,
  input  wire        ddc_perm_r_i,
  input  wire        ddc_perm_w_i,
  input  wire [63:0] ddc_base_i,
  input  wire [64:0] ddc_top_i,
  output reg         resp_valid_o,
  output reg         illegal_instr_o,
  output reg         load_misaligned_o,
  output reg         store_misaligned_o,
  output reg         store_access_fault_o,
  output reg         cap_fault_o,
  output reg  [3:0]  fault_type_o,
  output reg  [4:0]  fault_cause_o,
  output reg         mem_req_valid_o,
  output reg         mem_write_o,
  output reg         mem_reserve_o,
  output reg         mem_cap_width_o,
  output reg  [2:0]  mem_size_o,
  output reg  [63:0] mem_addr_o,
  output reg  [4:0]  rd_index_o,
  output reg  [4:0]  src_index_o
);
  wire [6:0]  opcode = instr_i[6:0];
  wire [2:0]  width  = instr_i[14:12];
  wire [4:0]  funct5 = instr_i[31:27];

  reg         is_lr;
  reg         is_sc;
  reg         is_fl;
  reg         is_fs;
  reg         is_cap_w;
  reg         legal;
  reg         mode_ext;
  reg  [2:0]  size_log2;
  reg  [63:0] offset;
  reg  [63:0] eff_addr;
  reg  [4:0]  nbytes;
  reg  [4:0]  align_mask;
  reg         auth_tag;
  reg         auth_sealed;
  reg         auth_perm_r;
  reg         auth_perm_w;
  reg  [63:0] auth_base;
  reg  [64:0] auth_top;
  reg         misaligned;
  reg  [4:0]  next_cause;
  wire        in_bounds;

  always @* begin
    is_lr    = (opcode == `CACCS_OP_AMO) && (funct5 == `CACCS_F5_LR) && (instr_i[24:20] == 5'h00);
    is_sc    = (opcode == `CACCS_OP_AMO) && (funct5 == `CACCS_F5_SC);
    is_fl    = (opcode == `CACCS_OP_LOAD_FP);
    is_fs    = (opcode == `CACCS_OP_STORE_FP);
    mode_ext = cap_mode_i ? cfg_purecap_i : cfg_legacy_i;
    // A 32-bit base reuses the doubleword width code for the capability form.
    is_cap_w = (is_lr || is_sc) && (cfg_rv64_i ? (width == `CACCS_W_Q) : (width == `CACCS_W_D)); // R14
    size_log2 = width;
    if (is_cap_w) begin
      size_log2 = cfg_rv64_i ? `CACCS_SZ_CAP64 : `CACCS_SZ_CAP32;
    end
    legal = 1'b0;
    if (is_lr || is_sc) begin
      if (is_cap_w) begin
        legal = mode_ext && cfg_ext_a_i; // R12
      end else if (width == `CACCS_W_D) begin
        legal = cfg_rv64_i && mode_ext && cfg_ext_a_i; // R11
      end else if (width == `CACCS_W_W) begin
        legal = mode_ext && cfg_ext_a_i; // R12
      end else if (width == `CACCS_W_H || width == `CACCS_W_B) begin
        legal = mode_ext && cfg_zabhlrsc_i; // R11
      end
    end else if (is_fl || is_fs) begin
      if (width == `CACCS_W_D) begin
        legal = mode_ext && cfg_ext_d_i; // R13
      end else if (width == `CACCS_W_W) begin
        legal = mode_ext && cfg_ext_f_i; // R13
      end else if (width == `CACCS_W_H) begin
        legal = mode_ext && cfg_zfh_i; // R13
      end
    end
    // Reserved and conditional forms always address the base at offset zero.
    offset = 64'h0; // R15
    if (is_fl) begin
      offset = {{52{instr_i[31]}}, instr_i[31:20]};
    end else if (is_fs) begin
      offset = {{52{instr_i[31]}}, instr_i[31:25], instr_i[11:7]};
    end
    if (cap_mode_i) begin
      eff_addr    = base_cap_addr_i + offset; // R01
      auth_tag    = base_cap_tag_i;
      auth_sealed = base_cap_sealed_i;
      auth_perm_r = base_cap_perm_r_i;
      auth_perm_w = base_cap_perm_w_i;
      auth_base   = base_cap_base_i;
      auth_top    = base_cap_top_i;
    end else begin
      eff_addr    = int_base_addr_i + offset; // R02
      auth_tag    = ddc_tag_i;
      auth_sealed = ddc_sealed_i;
      auth_perm_r = ddc_perm_r_i;
      auth_perm_w = ddc_perm_w_i;
      auth_base   = ddc_base_i;
      auth_top    = ddc_top_i;
    end
    nbytes     = 5'h01 << size_log2;
    align_mask = nbytes - 5'h01;
    misaligned = (eff_addr[4:0] & align_mask) != 5'h00;
    // Fixed order keeps the reported cause stable when several checks fail.
    if (!auth_tag) begin
      next_cause = `CACCS_CAUSE_TAG; // R03 R16
    end else if (auth_sealed) begin
      next_cause = `CACCS_CAUSE_SEAL; // R04 R16
    end else if ((is_lr || is_fl) && !auth_perm_r) begin
      next_cause = `CACCS_CAUSE_PERM; // R05 R16
    end else if ((is_sc || is_fs) && !auth_perm_w) begin
      next_cause = `CACCS_CAUSE_PERM; // R06 R16
    end else if (!in_bounds) begin
      next_cause = `CACCS_CAUSE_LEN; // R07 R16
    end else begin
      next_cause = `CACCS_CAUSE_NONE;
    end
  end

  caccs_bounds u_bounds (
    .addr_i      (eff_addr),
    .bytes_i     (nbytes),
    .base_i      (auth_base),
    .top_i       (auth_top),
    .in_bounds_o (in_bounds)
  );

  // Every result is registered, so the answer follows the request by exactly one edge.
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      resp_valid_o         <= 1'b0;
      illegal_instr_o      <= 1'b0;
      load_misaligned_o    <= 1'b0;
      store_misaligned_o   <= 1'b0;
      store_access_fault_o <= 1'b0;
      cap_fault_o          <= 1'b0;
      fault_type_o         <= `CACCS_TYPE_NONE;
      fault_cause_o        <= `CACCS_CAUSE_NONE;
      mem_req_valid_o      <= 1'b0;
      mem_write_o          <= 1'b0;
      mem_reserve_o        <= 1'b0;
      mem_cap_width_o      <= 1'b0;
      mem_size_o           <= 3'h0;
      mem_addr_o           <= 64'h0;
      rd_index_o           <= 5'h00;
      src_index_o          <= 5'h00;
    end else begin
      resp_valid_o         <= req_valid_i;
      illegal_instr_o      <= req_valid_i && !legal;
      cap_fault_o          <= req_valid_i && legal && (next_cause != `CACCS_CAUSE_NONE);
      fault_type_o         <= (req_valid_i && legal && (next_cause != `CACCS_CAUSE_NONE)) ?
                              `CACCS_TYPE_DATA : `CACCS_TYPE_NONE; // R08
      fault_cause_o        <= (req_valid_i && legal) ? next_cause : `CACCS_CAUSE_NONE; // R08
      // Alignment faults are reported only when the authority checks pass.
      load_misaligned_o    <= req_valid_i && legal && (next_cause == `CACCS_CAUSE_NONE) &&
                              is_lr && misaligned; // R09
      store_misaligned_o   <= req_valid_i && legal && (next_cause == `CACCS_CAUSE_NONE) &&
                              is_sc && misaligned && cfg_zam_i; // R10
      store_access_fault_o <= req_valid_i && legal && (next_cause == `CACCS_CAUSE_NONE) &&
                              is_sc && misaligned && !cfg_zam_i; // R10
      mem_req_valid_o      <= req_valid_i && legal && (next_cause == `CACCS_CAUSE_NONE) &&
                              !((is_lr || is_sc) && misaligned);
      mem_write_o          <= is_sc || is_fs;
      mem_reserve_o        <= is_lr || is_sc;
      mem_cap_width_o      <= is_cap_w;
      mem_size_o           <= size_log2;
      mem_addr_o           <= eff_addr;
      rd_index_o           <= instr_i[11:7]; // R15
      src_index_o          <= instr_i[24:20]; // R15
    end
  end
endmodule
`default_nettype wire

// file: design/caccs_regs.vh
// Constants for the capability access checker: decode fields, fault codes and sizes.
// Assumes inclusion by bare name from design files that need them.
`ifndef CACCS_REGS_VH
`define CACCS_REGS_VH

`define CACCS_OP_AMO        7'h2F
`define CACCS_OP_LOAD_FP    7'h07
`define CACCS_OP_STORE_FP   7'h27
`define CACCS_F5_LR         5'h02
`define CACCS_F5_SC         5'h03
`define CACCS_W_B           3'h0
`define CACCS_W_H           3'h1
`define CACCS_W_W           3'h2
`define CACCS_W_D           3'h3
`define CACCS_W_Q           3'h4
`define CACCS_SZ_CAP64      3'h4
`define CACCS_SZ_CAP32      3'h3
`define CACCS_TYPE_NONE     4'h0
`define CACCS_TYPE_DATA     4'h1
`define CACCS_CAUSE_NONE    5'h00
`define CACCS_CAUSE_TAG     5'h01
`define CACCS_CAUSE_SEAL    5'h02
`define CACCS_CAUSE_PERM    5'h03
`define CACCS_CAUSE_LEN     5'h04

`endif

// file: tb/caccs_mem_model.sv
// Memory path stand-in: counts the accesses that the checker lets through.
// Assumes at most one access per cycle on the core clock.
`timescale 1ns/1ps
`default_nettype none
module caccs_mem_model (
  input  wire logic clk_sys_i,
  input  wire logic reset_n_i,
  input  wire logic mem_req_valid_i,
  output var int    n_o
);
  always @(posedge clk_sys_i or negedge reset_n_i)
    if (!reset_n_i) n_o <= 0;
    else if (mem_req_valid_i === 1'b1) n_o <= n_o + 1;
endmodule
`default_nettype wire

// file: tb/caccs_props.sv
// Checker: assertions on the access checker's fault and access outputs.
// Assumes it is bound to caccs_checker and sees ports of the same names.
`timescale 1ns/1ps
`default_nettype none
module caccs_props (
  input wire logic       clk_sys_i,
  input wire logic       reset_n_i,
  input wire logic       req_valid_i,
  input wire logic       cap_mode_i,
  input wire logic       cfg_zam_i,
  input wire logic       base_cap_tag_i,
  input wire logic       base_cap_sealed_i,
  input wire logic       ddc_tag_i,
  input wire logic       illegal_instr_o,
  input wire logic       load_misaligned_o,
  input wire logic       store_misaligned_o,
  input wire logic       store_access_fault_o,
  input wire logic       cap_fault_o,
  input wire logic [3:0] fault_type_o,
  input wire logic [4:0] fault_cause_o,
  input wire logic       mem_req_valid_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  // An illegal op outranks every capability fault, so it is always an acceptable answer.
  sequence s_cap; req_valid_i && cap_mode_i; endsequence
  sequence s_cz(c); illegal_instr_o || (cap_fault_o && fault_cause_o == c); endsequence
  property p_tag; s_cap ##0 !base_cap_tag_i |=> s_cz(5'h01); endproperty
  a_tag: assert property (p_tag) else $error("tag cause missing");
  property p_ddc; req_valid_i && !cap_mode_i && !ddc_tag_i |=> s_cz(5'h01); endproperty
  a_ddc: assert property (p_ddc) else $error("default capability tag cause missing");
  property p_seal; s_cap ##0 base_cap_tag_i && base_cap_sealed_i |=> s_cz(5'h02); endproperty
  a_seal: assert property (p_seal) else $error("seal cause missing");
  property p_type; cap_fault_o |-> fault_type_o == 4'h1 && fault_cause_o != 5'h00; endproperty
  a_type: assert property (p_type) else $error("fault type or cause wrong");
  property p_none; !cap_fault_o |-> fault_type_o == 4'h0 && fault_cause_o == 5'h00; endproperty
  a_none: assert property (p_none) else $error("fault fields set without fault");
  property p_ld; load_misaligned_o |-> !cap_fault_o && !illegal_instr_o && !mem_req_valid_o; endproperty
  a_ld: assert property (p_ld) else $error("load misaligned with other outcome");
  property p_sc; store_misaligned_o || store_access_fault_o |->
    (store_misaligned_o ^ store_access_fault_o) && store_misaligned_o == $past(cfg_zam_i); endproperty
  a_sc: assert property (p_sc) else $error("store misaligned kind wrong");
  property p_mem; mem_req_valid_o |-> !(cap_fault_o || illegal_instr_o || load_misaligned_o); endproperty
  a_mem: assert property (p_mem) else $error("access issued despite fault");
endmodule
`default_nettype wire

// file: tb/tb_capability_access_checker.sv
// Testbench: one request per call, each answer compared with the value worked out by hand.
// Assumes the design files and caccs_regs.vh are on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "caccs_regs.vh"
module tb_capability_access_checker;
  logic        clk_sys_i, reset_n_i, req_valid_i, cap_mode_i, cfg_rv64_i, cfg_ext_a_i, cfg_purecap_i, cfg_legacy_i;
  logic        cfg_zabhlrsc_i, cfg_zam_i, cfg_ext_f_i, cfg_ext_d_i, cfg_zfh_i, ddc_tag_i, ddc_sealed_i, ddc_perm_r_i;
  logic        ddc_perm_w_i, base_cap_tag_i, base_cap_sealed_i, base_cap_perm_r_i, base_cap_perm_w_i;
  logic [31:0] instr_i;
  logic [63:0] int_base_addr_i, base_cap_addr_i, base_cap_base_i, ddc_base_i;
  logic [64:0] base_cap_top_i, ddc_top_i;
  wire         resp_valid_o, illegal_instr_o, load_misaligned_o, store_misaligned_o, store_access_fault_o;
  wire         cap_fault_o, mem_req_valid_o, mem_write_o, mem_reserve_o, mem_cap_width_o;
  wire [3:0]   fault_type_o;
  wire [4:0]   fault_cause_o, rd_index_o, src_index_o;
  wire [2:0]   mem_size_o;
  wire [63:0]  mem_addr_o;
  int          n_mismatch, total_checks, n_ok, n_acc;
  caccs_checker DUT (.*);
  caccs_mem_model u_mem (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .mem_req_valid_i(mem_req_valid_o),
                         .n_o(n_acc));
  function automatic [31:0] ins(input [4:0] f, input [2:0] w, input [6:0] op);
    ins = {f, 12'h001, w, 5'h00, op};
  endfunction
  task automatic chk(input string nm, input [63:0] e, input [63:0] g);
    total_checks++;
    if (e !== g) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Flags apply to both capabilities; only the bounds differ, so the chosen authority shows.
  task automatic set(input [8:0] cf, input [4:0] md, input [15:0] a);
    {cfg_zfh_i, cfg_ext_d_i, cfg_ext_f_i, cfg_zam_i, cfg_zabhlrsc_i, cfg_legacy_i, cfg_purecap_i} = cf[8:2];
    {cfg_ext_a_i, cfg_rv64_i} = cf[1:0];
    {cap_mode_i, base_cap_tag_i, base_cap_sealed_i, base_cap_perm_r_i, base_cap_perm_w_i} = md;
    {ddc_tag_i, ddc_sealed_i, ddc_perm_r_i, ddc_perm_w_i} = md[3:0];
    base_cap_addr_i = {48'h0, a};
    int_base_addr_i = {48'h0, a};
  endtask
  task automatic go(input [31:0] i, input [8:0] cf, input [4:0] md, input [15:0] a, input [4:0] c, input [4:0] f);
    set(cf, md, a);
    instr_i = i;
    req_valid_i = 1'b1;
    @(posedge clk_sys_i);
    #1;
    req_valid_i = 1'b0;
    chk("answer", {1'b1, c != 5'h00, c != 5'h00 ? `CACCS_TYPE_DATA : `CACCS_TYPE_NONE, c, f},
        {resp_valid_o, cap_fault_o, fault_type_o, fault_cause_o, illegal_instr_o, load_misaligned_o,
         store_misaligned_o, store_access_fault_o, mem_req_valid_o});
    if (f[0]) n_ok++;
    if (f[0]) chk("address", {48'h0, a}, mem_addr_o);
    @(posedge clk_sys_i);
    #1;
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    repeat (2000) @(posedge clk_sys_i);
    n_mismatch++;
    test_done;
  end
  initial begin
    reset_n_i = 1'b0;
    req_valid_i = 1'b0;
    instr_i = 32'h0;
    base_cap_base_i = 64'h1000;
    base_cap_top_i = 65'h2000;
    ddc_base_i = 64'h0;
    ddc_top_i = 65'h2000;
    set(9'h1FF, 5'h1B, 16'h1000);
    repeat (3) @(posedge clk_sys_i);
    #1;
    reset_n_i = 1'b1;
    go(ins(5'h02, 3'h2, 7'h2F), 9'h1FF, 5'h1B, 16'h1000, 5'h00, 5'h01);
    go(ins(5'h02, 3'h2, 7'h2F), 9'h1FF, 5'h0B, 16'h0FFC, 5'h00, 5'h01);
    go(ins(5'h02, 3'h2, 7'h2F), 9'h1FF, 5'h1B, 16'h0FFC, 5'h04, 5'h00);
    go(ins(5'h02, 3'h2, 7'h2F), 9'h1FF, 5'h13, 16'h1000, 5'h01, 5'h00);
    go(ins(5'h02, 3'h2, 7'h2F), 9'h1FF, 5'h03, 16'h1000, 5'h01, 5'h00);
    go(ins(5'h02, 3'h2, 7'h2F), 9'h1FF, 5'h14, 16'h0FFC, 5'h01, 5'h00);
    go(ins(5'h03, 3'h2, 7'h2F), 9'h1FF, 5'h1C, 16'h0FFC, 5'h02, 5'h00);
    go(ins(5'h02, 3'h2, 7'h2F), 9'h1FF, 5'h19, 16'h2000, 5'h03, 5'h00);
    go(ins(5'h00, 3'h2, 7'h07), 9'h1FF, 5'h19, 16'h1000, 5'h03, 5'h00);
    go(ins(5'h03, 3'h2, 7'h2F), 9'h1FF, 5'h1A, 16'h1000, 5'h03, 5'h00);
    go(ins(5'h00, 3'h2, 7'h27), 9'h1FF, 5'h1A, 16'h1000, 5'h03, 5'h00);
    go(ins(5'h00, 3'h2, 7'h07), 9'h1FF, 5'h1B, 16'h1FFC, 5'h00, 5'h01);
    go(ins(5'h00, 3'h3, 7'h07), 9'h1FF, 5'h1B, 16'h1FFC, 5'h04, 5'h00);
    go(ins(5'h02, 3'h2, 7'h2F), 9'h1FF, 5'h1B, 16'h1002, 5'h00, 5'h08);
    go(ins(5'h02, 3'h4, 7'h2F), 9'h1FF, 5'h1B, 16'h1008, 5'h00, 5'h08);
    go(ins(5'h03, 3'h2, 7'h2F), 9'h1FF, 5'h1B, 16'h1002, 5'h00, 5'h04);
    go(ins(5'h03, 3'h2, 7'h2F), 9'h1DF, 5'h1B, 16'h1002, 5'h00, 5'h02);
    // On a 32-bit base the doubleword width code is the capability form, so no doubleword store exists there.
    go(ins(5'h03, 3'h3, 7'h2F), 9'h1FE, 5'h1B, 16'h1000, 5'h00, 5'h01);
    chk("sc_d_rv32", {1'b1, `CACCS_SZ_CAP32}, {mem_cap_width_o, mem_size_o});
    go(ins(5'h03, 3'h3, 7'h2F), 9'h1FF, 5'h1B, 16'h1008, 5'h00, 5'h01);
    chk("sc_d_rv64", {1'b0, `CACCS_W_D}, {mem_cap_width_o, mem_size_o});
    go(ins(5'h03, 3'h0, 7'h2F), 9'h1EF, 5'h1B, 16'h1000, 5'h00, 5'h10);
    go(ins(5'h02, 3'h2, 7'h2F), 9'h1FB, 5'h1B, 16'h1000, 5'h00, 5'h10);
    go(ins(5'h02, 3'h2, 7'h2F), 9'h1F7, 5'h0B, 16'h1000, 5'h00, 5'h10);
    go(ins(5'h00, 3'h3, 7'h07), 9'h17F, 5'h1B, 16'h1000, 5'h00, 5'h10);
    go(ins(5'h00, 3'h1, 7'h27), 9'h0FF, 5'h1B, 16'h1000, 5'h00, 5'h10);
    go(ins(5'h02, 3'h3, 7'h2F), 9'h1FE, 5'h1B, 16'h1008, 5'h00, 5'h01);
    go(ins(5'h02, 3'h4, 7'h2F), 9'h1FE, 5'h1B, 16'h1000, 5'h00, 5'h10);
    // Nonzero result and source fields show that each index comes from its own slice.
    go({5'h03, 7'h0A, 5'h01, 3'h4, 5'h05, 7'h2F}, 9'h1FF, 5'h1B, 16'h1000, 5'h00, 5'h01);
    chk("sc_cap", {3'h7, `CACCS_SZ_CAP64}, {mem_write_o, mem_reserve_o, mem_cap_width_o, mem_size_o});
    chk("sc_regs", {5'h05, 5'h0A}, {rd_index_o, src_index_o});
    chk("accesses", n_ok, n_acc);
    test_done;
  end
endmodule
bind caccs_checker caccs_props u_props (.*);
`default_nettype wire
